// ---- bench/gp_board.sv ----
// Board model at the port pins: resolves each wire from both drivers.
// Assumes the testbench supplies the board's own drive value.
`timescale 1ns/100ps

module gp_board (
	// Design side
	input gp_pkg::gp_pins_type pin_o_i,
	input gp_pkg::gp_pins_type pin_oe_i,
	// Board side
	input gp_pkg::gp_pins_type drive_i,
	output gp_pkg::gp_pins_type level_o
);
	// Released bits, open-drain highs too, follow the board
	assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drive_i);
endmodule : gp_board

// ---- bench/gp_ports_chk.sv ----
// Concurrent checks on the port block's APB answers and pin enables.
// Assumes it is bound to gp_ports and sees only that module's ports.
`timescale 1ns/100ps

module gp_ports_chk (
	// Clock and reset
	input logic sys_clk_i,
	input logic rst_i,
	// APB slave
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [13:0] paddr_i,
	input logic [31:0] pwdata_i,
	input logic [3:0] pstrb_i,
	input logic [31:0] prdata_o,
	input logic pready_o,
	input logic pslverr_o,
	// Pins
	input gp_pkg::gp_pins_type pin_i,
	input gp_pkg::gp_pins_type pin_o,
	input gp_pkg::gp_pins_type pin_oe_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_done;
		psel_i && penable_i && pready_o;
	endsequence
	sequence s_rd;
		s_done ##0 !pwrite_i;
	endsequence

	property p_rdy;
		s_setup |=> s_done ##1 !pready_o;
	endproperty
	property p_hi;
		pready_o |-> prdata_o[31:16] == 16'h0000;
	endproperty
	property p_c_rd;
		s_rd ##0 (paddr_i[13:5] == 9'h05A)
			|-> (prdata_o[15:0] & ~16'hF01E) == 16'h0000;
	endproperty
	property p_e_rd;
		s_rd ##0 (paddr_i[13:5] == 9'h05C) |-> prdata_o[15:10] == 6'h00;
	endproperty
	property p_oe_c;
		(pin_oe_o[0] & ~16'hF01E) == 16'h0000;
	endproperty
	property p_oe_e;
		pin_oe_o[2][15:10] == 6'h00;
	endproperty
	property p_rst;
		$past(rst_i) |-> pin_oe_o == 48'h0000_0000_0000 && !pready_o;
	endproperty
	property p_err;
		s_done ##0 (paddr_i[1:0] != 2'b00)
			|-> pslverr_o && prdata_o == 32'h0000_0000;
	endproperty

	a_rdy: assert property (p_rdy) else $error("bad answer timing");
	a_hi: assert property (p_hi) else $error("upper half set");
	a_c_rd: assert property (p_c_rd) else $error("port c gap bit");
	a_e_rd: assert property (p_e_rd) else $error("port e gap bit");
	a_oe_c: assert property (p_oe_c) else $error("port c gap driven");
	a_oe_e: assert property (p_oe_e) else $error("port e gap driven");
	a_rst: assert property (p_rst) else $error("driving after reset");
	a_err: assert property (p_err) else $error("misaligned accepted");
endmodule : gp_ports_chk

bind gp_ports gp_ports_chk chk_u (.sys_clk_i, .rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
	.pslverr_o, .pin_i, .pin_o, .pin_oe_o);

// ---- bench/tb.sv ----
// Self-checking bench for the port block, APB master tasks and board.
// Assumes gp_pkg, gp_board and the checker are compiled before it.
`timescale 1ns/100ps

module tb;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rdat;
	logic rerr;
	gp_pkg::gp_pins_type pin_i;
	gp_pkg::gp_pins_type pin_o;
	gp_pkg::gp_pins_type pin_oe;
	gp_pkg::gp_pins_type drive = 48'h0000_0000_0000;
	int mismatches = 0;
	int cmp_count = 0;

	always #4 sys_clk = ~sys_clk;

	gp_ports dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(pin_oe));
	gp_board board_u (.pin_o_i(pin_o), .pin_oe_i(pin_oe),
		.drive_i(drive), .level_o(pin_i));

	task automatic give_verdict;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [13:0] a,
			input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Slave answer time is left open; only the watchdog ends the wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [13:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask : rd

	initial begin
		#40000;
		mismatches++;
		give_verdict;
	end

	initial begin
		logic [15:0] e;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(14'h0B40, 32'h0000_F01E);
		rd(14'h0B60, 32'h0000_FFFF);
		rd(14'h0B80, 32'h0000_03FF);
		for (int i = 0; i < 3; i++) begin
			rd(14'h0B58 + 14'(i * 32), 32'h0000_0000);
		end
		apb(1'b1, 14'h0B58, 32'hFFFF_FFFF);
		rd(14'h0B58, 32'h0000_F01E);
		apb(1'b1, 14'h0B98, 32'hFFFF_FFFF);
		rd(14'h0B98, 32'h0000_03FF);
		drive <= {16'h0000, 16'h5A00, 16'hFFFF};
		apb(1'b1, 14'h0B70, 32'h0000_00A5);
		apb(1'b1, 14'h0B78, 32'h0000_0004);
		apb(1'b1, 14'h0B60, 32'h0000_FF00);
		repeat (2) @(posedge sys_clk);
		chk({16'h0000, pin_oe[1]}, 32'h0000_00FB);
		chk({16'h0000, pin_o[1]}, 32'h0000_00A1);
		rd(14'h0B68, 32'h0000_5AA1);
		apb(1'b1, 14'h0BE8, 32'h0000_001C);
		rd(14'h0B40, 32'h0000_F000);
		rd(14'h0B60, 32'h0000_0F00);
		apb(1'b1, 14'h0BE8, 32'h0000_001D);
		apb(1'b1, 14'h0B40, 32'h0000_FFFF);
		rd(14'h0B40, 32'h0000_F00A);
		apb(1'b1, 14'h0BE8, 32'h0000_001F);
		apb(1'b1, 14'h0B40, 32'h0000_FFFF);
		for (int v = 0; v < 8; v++) begin
			apb(1'b1, 14'h0BE8, 32'(v * 4 + 3));
			e = 16'hF01E;
			if (v[1:0] == 2'b01 || v[1:0] == 2'b10) begin
				e = e & 16'h6FFF;
			end
			if (v[2] == 1'b0) begin
				e = e & 16'h7FFF;
			end
			rd(14'h0B48, {16'h0000, e});
		end
		// Variant code 10 is no package: the old variant must stay
		apb(1'b1, 14'h0BE8, 32'h0000_001A);
		rd(14'h0BE8, 32'h0000_001B);
		rd(14'h0B40, 32'h0000_F01E);
		// Config write with its low byte lane off is dropped
		pstrb <= 4'h2;
		apb(1'b1, 14'h0BE8, 32'h0000_001C);
		pstrb <= 4'hF;
		rd(14'h0BE8, 32'h0000_001B);
		apb(1'b0, 14'h0BFC, 32'h0000_0000);
		chk({31'h0000_0000, rerr}, 32'h0000_0001);
		chk(rdat, 32'h0000_0000);
		apb(1'b1, 14'h0B42, 32'hFFFF_FFFF);
		chk({31'h0000_0000, rerr}, 32'h0000_0001);
		give_verdict;
	end
endmodule : tb

// ---- verilog/gp_bank.sv ----
// Direction, latch and open-drain registers of one port.
// Assumes write strobes are single-cycle and the mask is current.
`timescale 1ns/100ps
`include "gp_map.svh"

module gp_bank #(
	parameter logic [15:0] DIR_RST = 16'hFFFF
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Write side
	input wire logic wr_dir_i,
	input wire logic wr_lat_i,
	input wire logic wr_od_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0] be_i,
	input wire logic [15:0] mask_i,
	// State
	output gp_pkg::gp_regs_type regs_o
);

	gp_pkg::gp_regs_type regs_r;
	gp_pkg::gp_regs_type regs_nxt;

	always_comb begin
		regs_nxt = regs_r;
		if (wr_dir_i) begin
			regs_nxt.dir = gp_pkg::gp_merge(regs_r.dir, wdata_i, be_i);
		end
		if (wr_lat_i) begin
			regs_nxt.lat = gp_pkg::gp_merge(regs_r.lat, wdata_i, be_i);
		end
		if (wr_od_i) begin
			regs_nxt.od = gp_pkg::gp_merge(regs_r.od, wdata_i, be_i);
		end
		// Absent bits forced low every cycle, so a variant change clears them
		regs_nxt.dir = regs_nxt.dir & mask_i; // [RL1] [RL8]
		regs_nxt.lat = regs_nxt.lat & mask_i; // [RL1] [RL8]
		regs_nxt.od = regs_nxt.od & mask_i; // [RL1] [RL8]
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			regs_r.dir <= DIR_RST; // [RL6]
			regs_r.lat <= `GP_RST_LAT; // [RL7]
			regs_r.od <= `GP_RST_OD; // [RL6]
		end else begin
			regs_r <= regs_nxt;
		end
	end

	assign regs_o = regs_r;

endmodule : gp_bank

// ---- verilog/gp_map.svh ----
// Register indices, bit masks, reset values and config fields for the
// three general-purpose ports. Assumes APB byte address = index * 4.
//
// What this block does
// RL1 - Unimplemented bits read zero and ignore writes.
// RL2 - Port C bits 4 and 2 exist only on the 100-pin variant.
// RL3 - Port C bits 3,1 and port D bits 15:12 absent on 64-pin variant.
// RL4 - Port C pin bits 12 and 15 read zero unless oscillator mode 11/00.
// RL5 - Port C pin bit 15 also needs the oscillator-output-as-io bit set.
// RL6 - Reset sets implemented direction bits; open-drain selects clear.
// RL7 - Pin read and latch registers reset to zero.
// RL8 - Smaller variants hold bits absent in their package at zero.
// RL9 - Port C implements bits 15:12 and 4:1 only, direction at 02D0.
// RL10 - Direction set means input; open-drain drives low only.
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

// Register indices
`define GP_IDX_C_DIR 12'h02D0
`define GP_IDX_C_PIN 12'h02D2
`define GP_IDX_C_LAT 12'h02D4
`define GP_IDX_C_OD 12'h02D6
`define GP_IDX_D_DIR 12'h02D8
`define GP_IDX_D_PIN 12'h02DA
`define GP_IDX_D_LAT 12'h02DC
`define GP_IDX_D_OD 12'h02DE
`define GP_IDX_E_DIR 12'h02E0
`define GP_IDX_E_PIN 12'h02E2
`define GP_IDX_E_LAT 12'h02E4
`define GP_IDX_E_OD 12'h02E6
`define GP_IDX_CFG 12'h02FA

// Implemented bits on the largest package
`define GP_MASK_C 16'hF01E
`define GP_MASK_D 16'hFFFF
`define GP_MASK_E 16'h03FF
`define GP_C_ONLY_100 16'h0014
`define GP_C_NOT_64 16'h000A
`define GP_D_NOT_64 16'hF000
`define GP_C_OSC_BITS 16'h9000
`define GP_C_BIT15 16'h8000

// Reset values
`define GP_RST_OD 16'h0000
`define GP_RST_LAT 16'h0000
`define GP_RST_WORD 32'h0000_0000
`define GP_ZERO16 16'h0000

// Config register fields and reset
`define GP_CFG_VAR_LSB 0
`define GP_CFG_POSC_LSB 2
`define GP_CFG_OSCIO_BIT 4
`define GP_CFG_RST 5'h1F
`define GP_POSC_OFF 2'h3
`define GP_POSC_EXT_CLK 2'h0

`endif

// ---- verilog/gp_pad.sv ----
// Pin drive and sampling for one 16-bit port.
// Assumes pin inputs are synchronous to sys_clk_i.
`timescale 1ns/100ps
`include "gp_map.svh"

module gp_pad (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Register side
	input gp_pkg::gp_regs_type regs_i,
	input wire logic [15:0] mask_i,
	output logic [15:0] level_o,
	// Pins
	input wire logic [15:0] pin_i,
	output logic [15:0] pin_o,
	output logic [15:0] pin_oe_o
);

	logic [15:0] out_r;
	logic [15:0] out_nxt;
	logic [15:0] oe_r;
	logic [15:0] oe_nxt;
	logic [15:0] level_r;
	logic [15:0] level_nxt;

	always_comb begin
		out_nxt = regs_i.lat & ~regs_i.od; // [RL10]
		// Open-drain releases the pin when the latch is high
		oe_nxt = mask_i & ~regs_i.dir & (~regs_i.od | ~regs_i.lat); // [RL10]
		level_nxt = pin_i & mask_i; // [RL10]
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_r <= `GP_ZERO16;
			oe_r <= `GP_ZERO16;
			level_r <= `GP_ZERO16;
		end else begin
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			level_r <= level_nxt;
		end
	end

	assign pin_o = out_r;
	assign pin_oe_o = oe_r;
	assign level_o = level_r;

endmodule : gp_pad

// ---- verilog/gp_pkg.sv ----
// Types and shared helpers for the general-purpose port block.
// Assumes gp_map.svh is on the include path.
`include "gp_map.svh"

package gp_pkg;

	typedef enum logic [1:0] {
		GP_PKG_64 = 2'b00,
		GP_PKG_80 = 2'b01,
		GP_PKG_100 = 2'b11
	} gp_variant_type;

	typedef enum logic [1:0] {
		GP_ST_IDLE = 2'b00,
		GP_ST_ACCESS = 2'b01
	} gp_state_type;

	typedef struct packed {
		logic [15:0] dir;
		logic [15:0] lat;
		logic [15:0] od;
	} gp_regs_type;

	// Low bits first: variant [1:0], oscillator mode [3:2], osc-io [4]
	typedef struct packed {
		logic oscio;
		logic [1:0] posc;
		gp_variant_type variant;
	} gp_cfg_type;

	typedef logic [2:0][15:0] gp_pins_type;

	// Implemented bits of port p (0=C, 1=D, 2=E) for a package variant
	function automatic logic [15:0] gp_impl_mask(input int p,
			input gp_variant_type v);
		logic [15:0] m;
		m = (p == 0) ? `GP_MASK_C : (p == 1) ? `GP_MASK_D : `GP_MASK_E;
		if (p == 0 && v != GP_PKG_100) begin
			m = m & ~`GP_C_ONLY_100; // [RL2]
		end
		// Each port loses only its own absent bits
		if (p == 0 && v == GP_PKG_64) begin
			m = m & ~`GP_C_NOT_64; // [RL3]
		end
		if (p == 1 && v == GP_PKG_64) begin
			m = m & ~`GP_D_NOT_64; // [RL3]
		end
		if (p == 2) begin
			m = m & `GP_MASK_E;
		end
		return m;
	endfunction : gp_impl_mask

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] gp_merge(input logic [15:0] old,
			input logic [15:0] wd, input logic [1:0] be);
		logic [15:0] bm;
		bm = {{8{be[1]}}, {8{be[0]}}};
		return (old & ~bm) | (wd & bm);
	endfunction : gp_merge

endpackage : gp_pkg

// ---- verilog/gp_ports.sv ----
// Top of the port C/D/E block: APB slave, decode, config, read mux.
// Assumes an APB master on sys_clk_i and board pins synchronous to it.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "gp_map.svh"

module gp_ports (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins, index 0 = C, 1 = D, 2 = E
	input gp_pkg::gp_pins_type pin_i,
	output gp_pkg::gp_pins_type pin_o,
	output gp_pkg::gp_pins_type pin_oe_o
);

	// Bus state
	gp_pkg::gp_state_type state_r;
	gp_pkg::gp_state_type state_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// Config state
	gp_pkg::gp_cfg_type cfg_r;
	gp_pkg::gp_cfg_type cfg_nxt;

	// Decode
	logic [11:0] idx;
	logic setup;
	logic commit;
	logic hit;
	logic [2:0] wr_dir;
	logic [2:0] wr_lat;
	logic [2:0] wr_od;
	logic wr_cfg;
	logic [15:0] rd_word;

	// Per port
	gp_pkg::gp_regs_type regs [3];
	logic [15:0] level [3];
	logic [15:0] mask [3];
	logic [15:0] pin_read [3];
	logic [15:0] c_osc_mask;

	assign idx = paddr_i[13:2];
	assign setup = psel_i && !penable_i;
	// Writes land only on the edge that completes the access
	assign commit = psel_i && penable_i && pready_r && pwrite_i;

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			mask[p] = gp_pkg::gp_impl_mask(p, cfg_r.variant); // [RL9]
		end
	end

	// Port C pin reads of bits 12/15 vanish while the oscillator owns them
	always_comb begin
		c_osc_mask = `GP_MASK_C;
		if (cfg_r.posc != `GP_POSC_OFF &&
				cfg_r.posc != `GP_POSC_EXT_CLK) begin
			c_osc_mask = c_osc_mask & ~`GP_C_OSC_BITS; // [RL4]
		end
		if (!cfg_r.oscio) begin
			c_osc_mask = c_osc_mask & ~`GP_C_BIT15; // [RL5]
		end
	end

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			pin_read[p] = level[p] & mask[p]; // [RL1]
		end
		pin_read[0] = pin_read[0] & c_osc_mask; // [RL4] [RL5]
	end

	// Write decode
	always_comb begin
		wr_dir = 3'b000;
		wr_lat = 3'b000;
		wr_od = 3'b000;
		wr_cfg = 1'b0;
		if (commit && paddr_i[1:0] == 2'b00) begin
			case (idx)
				`GP_IDX_C_DIR: begin
					wr_dir[0] = 1'b1;
				end
				`GP_IDX_C_PIN: begin
					wr_lat[0] = 1'b1;
				end
				`GP_IDX_C_LAT: begin
					wr_lat[0] = 1'b1;
				end
				`GP_IDX_C_OD: begin
					wr_od[0] = 1'b1;
				end
				`GP_IDX_D_DIR: begin
					wr_dir[1] = 1'b1;
				end
				`GP_IDX_D_PIN: begin
					wr_lat[1] = 1'b1;
				end
				`GP_IDX_D_LAT: begin
					wr_lat[1] = 1'b1;
				end
				`GP_IDX_D_OD: begin
					wr_od[1] = 1'b1;
				end
				`GP_IDX_E_DIR: begin
					wr_dir[2] = 1'b1;
				end
				`GP_IDX_E_PIN: begin
					wr_lat[2] = 1'b1;
				end
				`GP_IDX_E_LAT: begin
					wr_lat[2] = 1'b1;
				end
				`GP_IDX_E_OD: begin
					wr_od[2] = 1'b1;
				end
				`GP_IDX_CFG: begin
					wr_cfg = 1'b1;
				end
				default: begin
					wr_cfg = 1'b0;
				end
			endcase
		end
	end

	// Read mux and address check
	always_comb begin
		rd_word = `GP_ZERO16;
		hit = 1'b1;
		case (idx)
			`GP_IDX_C_DIR: begin
				rd_word = regs[0].dir;
			end
			`GP_IDX_C_PIN: begin
				rd_word = pin_read[0];
			end
			`GP_IDX_C_LAT: begin
				rd_word = regs[0].lat;
			end
			`GP_IDX_C_OD: begin
				rd_word = regs[0].od;
			end
			`GP_IDX_D_DIR: begin
				rd_word = regs[1].dir;
			end
			`GP_IDX_D_PIN: begin
				rd_word = pin_read[1];
			end
			`GP_IDX_D_LAT: begin
				rd_word = regs[1].lat;
			end
			`GP_IDX_D_OD: begin
				rd_word = regs[1].od;
			end
			`GP_IDX_E_DIR: begin
				rd_word = regs[2].dir;
			end
			`GP_IDX_E_PIN: begin
				rd_word = pin_read[2];
			end
			`GP_IDX_E_LAT: begin
				rd_word = regs[2].lat;
			end
			`GP_IDX_E_OD: begin
				rd_word = regs[2].od;
			end
			`GP_IDX_CFG: begin
				rd_word = {11'h000, cfg_r};
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		if (paddr_i[1:0] != 2'b00) begin
			hit = 1'b0;
		end
	end

	// Zero-wait slave: answer is prepared in the setup cycle
	always_comb begin
		state_nxt = gp_pkg::GP_ST_IDLE;
		prdata_nxt = `GP_RST_WORD;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		case (state_r)
			gp_pkg::GP_ST_IDLE,
			gp_pkg::GP_ST_ACCESS: begin
				if (setup) begin
					state_nxt = gp_pkg::GP_ST_ACCESS;
					pready_nxt = 1'b1;
					pslverr_nxt = !hit;
					if (!pwrite_i && hit) begin
						prdata_nxt = {16'h0000, rd_word}; // [RL1]
					end
				end
			end
			default: begin
				state_nxt = gp_pkg::GP_ST_IDLE;
			end
		endcase
	end

	// Config register; bits above the fields read zero
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_cfg && pstrb_i[0]) begin
			cfg_nxt = pwdata_i[4:0];
		end
		// Encoding 10 is not a package; keep the old variant
		if (cfg_nxt.variant != gp_pkg::GP_PKG_64 &&
				cfg_nxt.variant != gp_pkg::GP_PKG_80 &&
				cfg_nxt.variant != gp_pkg::GP_PKG_100) begin
			cfg_nxt.variant = cfg_r.variant;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_r <= gp_pkg::GP_ST_IDLE;
			prdata_r <= `GP_RST_WORD;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			cfg_r <= `GP_CFG_RST;
		end else begin
			state_r <= state_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// Unused upper byte lanes are ignored; registers are 16 bits
	for (genvar p = 0; p < 3; p++) begin : g_port
		localparam logic [15:0] DIR_RST =
				(p == 0) ? `GP_MASK_C : (p == 1) ? `GP_MASK_D : `GP_MASK_E;

		gp_bank #(
			.DIR_RST(DIR_RST)
		) u_bank (
			.sys_clk_i(sys_clk_i),
			.rst_i(rst_i),
			.wr_dir_i(wr_dir[p]),
			.wr_lat_i(wr_lat[p]),
			.wr_od_i(wr_od[p]),
			.wdata_i(pwdata_i[15:0]),
			.be_i(pstrb_i[1:0]),
			.mask_i(mask[p]),
			.regs_o(regs[p])
		);

		gp_pad u_pad (
			.sys_clk_i(sys_clk_i),
			.rst_i(rst_i),
			.regs_i(regs[p]),
			.mask_i(mask[p]),
			.level_o(level[p]),
			.pin_i(pin_i[p]),
			.pin_o(pin_o[p]),
			.pin_oe_o(pin_oe_o[p])
		);
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;

endmodule : gp_ports
